// >>> rtl/bcf_map.svh
`ifndef BCF_MAP_SVH
`define BCF_MAP_SVH
// ----------------------------------------
// device register addresses and fields
// ----------------------------------------
`define BCF_CFG_ADDR 8'h56
`define BCF_LLEN_ADDR 8'hE0
`define BCF_DLY_ADDR 8'hE1
`define BCF_CFG_RST 8'h00
`define BCF_IL_BIT 7
`define BCF_DM_BIT 6
`define BCF_LINE_DEPTH 256
// ----------------------------------------
// timing counts
// ----------------------------------------
`define BCF_INT_DIV 4'h9
`define BCF_LINK_HALF 5'h0F
// ----------------------------------------
// host apb map
// ----------------------------------------
`define BCF_A_CTRL 8'h00
`define BCF_A_CMD 8'h04
`define BCF_A_STAT 8'h08
`define BCF_A_PIX 8'h0C
`endif

// >>> rtl/bcf_pkg.sv
package bcf_pkg;
   // transmit clock source, in field order 00..11
   typedef enum logic [1:0] {cm_dsi, cm_ext, cm_int, cm_dual} bcf_clk_mode_e;
   typedef logic [23:0] bcf_pix_t;
   typedef enum logic [1:0] {hs_idle, hs_issue, hs_wait} bcf_hst_e;
endpackage : bcf_pkg

// >>> rtl/bcf_if.sv
`timescale 1ns/1ps
interface bcf_if;
   import bcf_pkg::*;
   logic link_clk;
   logic pix_valid;
   logic pix_sol;
   logic pix_port;
   bcf_pix_t pix_data;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_ack;
   logic dual_input_en;
   logic indep_mode;
   logic port_sel;
   modport dev (input link_clk, pix_valid, pix_sol, pix_port, pix_data, reg_wr, reg_rd, reg_addr,
      reg_wdata, dual_input_en, indep_mode, port_sel, output reg_rdata, reg_ack);
   modport host (output link_clk, pix_valid, pix_sol, pix_port, pix_data, reg_wr, reg_rd, reg_addr,
      reg_wdata, dual_input_en, indep_mode, port_sel, input reg_rdata, reg_ack);
endinterface : bcf_if

// >>> rtl/bcf_dev.sv
`timescale 1ns/1ps
`include "bcf_map.svh"
module bcf_dev import bcf_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   bcf_if.dev lnk,
   input wire logic external_pixel_clock_in,
   input wire logic port0_pixel_clock_in,
   input wire logic port1_pixel_clock_in,
   output logic out_valid,
   output logic out_sol,
   output bcf_pix_t out_data,
   output logic tx0_tick,
   output logic tx1_tick
);
   // ----------------------------------------
   // input synchronisers and edge finding
   // ----------------------------------------
   logic [30:0] s1_reg, s2_reg;
   logic [3:0] prev_reg, rise;
   logic take, ps, pp;
   bcf_pix_t pd;
   // two flops on every pin and on the link clock and pixel signals; register and control signals are used directly
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 31'h0;
         s2_reg <= 31'h0;
         prev_reg <= 4'h0;
      end else if (ce) begin
         s1_reg <= {lnk.pix_data, lnk.pix_port, lnk.pix_sol, lnk.pix_valid, lnk.link_clk,
                    port1_pixel_clock_in, port0_pixel_clock_in, external_pixel_clock_in};
         s2_reg <= s1_reg;
         prev_reg <= s2_reg[3:0];
      end
   end
   // bit 0 ext, 1 ref0, 2 ref1, 3 link clock
   assign rise = s2_reg[3:0] & ~prev_reg;
   assign take = rise[3] & s2_reg[4];
   assign ps = s2_reg[5];
   assign pp = s2_reg[6];
   assign pd = s2_reg[30:7];
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic il_reg, il_next, dm_reg, dm_next, ack_reg, ack_next;
   bcf_clk_mode_e m0_reg, m0_next, m1_reg, m1_next, wm;
   logic [7:0] llen_reg, llen_next, dly_reg, dly_next, rd_reg, rd_next;
   // register writes and reads over the device port
   always_comb begin
      il_next = il_reg;
      dm_next = dm_reg;
      m0_next = m0_reg;
      m1_next = m1_reg;
      llen_next = llen_reg;
      dly_next = dly_reg;
      rd_next = rd_reg;
      ack_next = 1'b0;
      wm = bcf_clk_mode_e'(lnk.reg_wdata[1:0]);
      if (lnk.reg_wr) begin
         ack_next = 1'b1;
         case (lnk.reg_addr)
            `BCF_CFG_ADDR: begin
               il_next = lnk.reg_wdata[`BCF_IL_BIT];
               dm_next = lnk.reg_wdata[`BCF_DM_BIT];
               if (lnk.indep_mode) begin
                  if (lnk.port_sel) begin
                     m1_next = wm;
                  end else begin
                     m0_next = wm;
                  end
               end else if (wm != cm_dual) begin
                  m0_next = wm;
                  m1_next = wm;
               end
            end
            `BCF_LLEN_ADDR: llen_next = lnk.reg_wdata;
            `BCF_DLY_ADDR: dly_next = lnk.reg_wdata;
            default: ;
         endcase
      end else if (lnk.reg_rd) begin
         ack_next = 1'b1;
         case (lnk.reg_addr)
            `BCF_CFG_ADDR: rd_next = {il_reg, dm_reg, 4'h0,
               (lnk.indep_mode && lnk.port_sel) ? m1_reg : m0_reg};
            `BCF_LLEN_ADDR: rd_next = llen_reg;
            `BCF_DLY_ADDR: rd_next = dly_reg;
            default: rd_next = 8'h00;
         endcase
      end
   end
   // register state, all zero at reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         il_reg <= 1'b0;
         dm_reg <= 1'b0;
         m0_reg <= cm_dsi;
         m1_reg <= cm_dsi;
         llen_reg <= `BCF_CFG_RST;
         dly_reg <= `BCF_CFG_RST;
         rd_reg <= 8'h00;
         ack_reg <= 1'b0;
      end else if (ce) begin
         il_reg <= il_next;
         dm_reg <= dm_next;
         m0_reg <= m0_next;
         m1_reg <= m1_next;
         llen_reg <= llen_next;
         dly_reg <= dly_next;
         rd_reg <= rd_next;
         ack_reg <= ack_next;
      end
   end
   assign lnk.reg_rdata = rd_reg;
   assign lnk.reg_ack = ack_reg;
   // ----------------------------------------
   // transmit clock selection
   // ----------------------------------------
   logic [3:0] div_reg, div_next;
   logic int_tick, t0_reg, t0_next, t1_reg, t1_next;
   function automatic logic pick(input bcf_clk_mode_e m, input logic a, input logic b,
                                 input logic c, input logic d);
      case (m)
         cm_dsi: pick = a;
         cm_ext: pick = b;
         cm_int: pick = c;
         default: pick = d;
      endcase
   endfunction : pick
   // internal pixel clock from the free-running clock
   assign int_tick = (div_reg == `BCF_INT_DIV);
   always_comb begin
      div_next = int_tick ? 4'h0 : div_reg + 4'h1;
      t0_next = pick(m0_reg, rise[3], rise[0], int_tick, rise[1]);
      t1_next = pick(m1_reg, rise[3], rise[0], int_tick, rise[2]);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_reg <= 4'h0;
         t0_reg <= 1'b0;
         t1_reg <= 1'b0;
      end else if (ce) begin
         div_reg <= div_next;
         t0_reg <= t0_next;
         t1_reg <= t1_next;
      end
   end
   assign tx0_tick = t0_reg;
   assign tx1_tick = t1_reg;
   // ----------------------------------------
   // video rearrangement
   // ----------------------------------------
   bcf_pix_t mem0 [`BCF_LINE_DEPTH], mem1 [`BCF_LINE_DEPTH];
   logic [8:0] idx_reg, idx_next, idx1_reg, idx1_next, dp_reg, dp_next, len9, base, off;
   logic pv_reg, pv_next, drain_reg, drain_next, ov_reg, ov_next, os_reg, os_next, w0, w1, emit;
   bcf_pix_t pend_reg, pend_next, od_reg, od_next;
   logic [7:0] wa;
   assign len9 = {1'b0, llen_reg};
   // line indexing, buffering and output choice
   always_comb begin
      idx_next = idx_reg;
      idx1_next = idx1_reg;
      dp_next = dp_reg;
      drain_next = drain_reg;
      pv_next = 1'b0;
      pend_next = pend_reg;
      ov_next = 1'b0;
      os_next = 1'b0;
      od_next = od_reg;
      w0 = 1'b0;
      w1 = 1'b0;
      wa = 8'h00;
      emit = 1'b0;
      base = ps ? 9'h000 : (pp ? idx1_reg : idx_reg);
      off = base - len9;
      if (take) begin
         if (dm_reg && lnk.dual_input_en) begin
            if (!pp && base < len9) begin
               emit = 1'b1;
               od_next = pd;
               os_next = (base == 9'h000);
               idx_next = base + 9'h001;
               if (base + 9'h001 == len9) begin
                  drain_next = 1'b1;
                  dp_next = 9'h000;
               end
            end else if (pp && base < len9) begin
               w1 = 1'b1;
               wa = base[7:0];
               idx1_next = base + 9'h001;
            end
         end else if (il_reg && !pp) begin
            idx_next = base + 9'h001;
            if (base < len9) begin
               w0 = 1'b1;
               wa = base[7:0];
            end else if (base < {llen_reg, 1'b0}) begin
               emit = 1'b1;
               od_next = mem0[off[7:0]];
               os_next = (base == len9);
               pv_next = 1'b1;
               pend_next = pd;
            end
         end else if (!pp) begin
            emit = 1'b1;
            od_next = pd;
            os_next = ps;
         end
      end
      if (emit) begin
         ov_next = 1'b1;
      end else if (pv_reg) begin
         ov_next = 1'b1;
         od_next = pend_reg;
      end else if (drain_reg) begin
         if (dp_reg >= len9) begin
            drain_next = 1'b0;
         end else if (dp_reg < idx1_reg) begin
            ov_next = 1'b1;
            od_next = mem1[dp_reg[7:0]];
            dp_next = dp_reg + 9'h001;
         end
      end
   end
   // line buffers, no reset needed for pixel storage
   always_ff @(posedge clk) begin
      if (ce && w0) mem0[wa] <= pd;
      if (ce && w1) mem1[wa] <= pd;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx_reg <= 9'h000;
         idx1_reg <= 9'h000;
         dp_reg <= 9'h000;
         drain_reg <= 1'b0;
         pv_reg <= 1'b0;
         pend_reg <= 24'h000000;
         ov_reg <= 1'b0;
         os_reg <= 1'b0;
         od_reg <= 24'h000000;
      end else if (ce) begin
         idx_reg <= idx_next;
         idx1_reg <= idx1_next;
         dp_reg <= dp_next;
         drain_reg <= drain_next;
         pv_reg <= pv_next;
         pend_reg <= pend_next;
         ov_reg <= ov_next;
         os_reg <= os_next;
         od_reg <= od_next;
      end
   end
   assign out_valid = ov_reg;
   assign out_sol = os_reg;
   assign out_data = od_reg;
endmodule : bcf_dev

// >>> rtl/bcf_host.sv
`timescale 1ns/1ps
`include "bcf_map.svh"
module bcf_host import bcf_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   bcf_if.host lnk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [2:0] ctrl_reg, ctrl_next;
   logic [31:0] prd_reg, prd_next;
   logic rdy_reg, rdy_next, err_reg, err_next;
   bcf_hst_e st_reg, st_next;
   logic [7:0] ca_reg, ca_next, cw_reg, cw_next, rdv_reg, rdv_next;
   logic crd_reg, crd_next, wr_reg, wr_next, rd_reg, rd_next;
   logic pend_reg, pend_next, lclk_reg, lclk_next, lv_reg, lv_next;
   logic ls_reg, ls_next, lp_reg, lp_next, qs_reg, qs_next, qp_reg, qp_next;
   bcf_pix_t qd_reg, qd_next, ld_reg, ld_next;
   logic [4:0] div_reg, div_next;
   logic acc;

   assign acc = psel & penable & ~rdy_reg;

   // apb decode, command engine and link drive
   always_comb begin
      ctrl_next = ctrl_reg;
      prd_next = prd_reg;
      rdy_next = 1'b0;
      err_next = 1'b0;
      st_next = st_reg;
      ca_next = ca_reg;
      cw_next = cw_reg;
      crd_next = crd_reg;
      rdv_next = rdv_reg;
      wr_next = 1'b0;
      rd_next = 1'b0;
      pend_next = pend_reg;
      qs_next = qs_reg;
      qp_next = qp_reg;
      qd_next = qd_reg;
      lclk_next = lclk_reg;
      lv_next = lv_reg;
      ls_next = ls_reg;
      lp_next = lp_reg;
      ld_next = ld_reg;
      // link clock runs without pause
      div_next = (div_reg == `BCF_LINK_HALF) ? 5'h00 : div_reg + 5'h01;
      if (div_reg == `BCF_LINK_HALF) begin
         lclk_next = ~lclk_reg;
         if (lclk_reg) begin
            lv_next = pend_reg;
            ls_next = qs_reg;
            lp_next = qp_reg;
            ld_next = qd_reg;
            pend_next = 1'b0;
         end
      end
      case (st_reg)
         hs_issue: begin
            wr_next = ~crd_reg;
            rd_next = crd_reg;
            st_next = hs_wait;
         end
         hs_wait: begin
            if (lnk.reg_ack) begin
               rdv_next = crd_reg ? lnk.reg_rdata : rdv_reg;
               st_next = hs_idle;
            end
         end
         default: st_next = hs_idle;
      endcase
      if (acc) begin
         case (paddr)
            `BCF_A_CTRL: begin
               rdy_next = 1'b1;
               prd_next = {29'h0, ctrl_reg};
               if (pwrite) begin
                  ctrl_next = pwdata[2:0];
               end
            end
            `BCF_A_CMD: begin
               prd_next = {15'h0, crd_reg, ca_reg, cw_reg};
               if (!pwrite) begin
                  rdy_next = 1'b1;
               end else if (st_reg == hs_idle) begin
                  rdy_next = 1'b1;
                  cw_next = pwdata[7:0];
                  ca_next = pwdata[15:8];
                  crd_next = pwdata[16];
                  st_next = hs_issue;
               end
            end
            `BCF_A_STAT: begin
               rdy_next = 1'b1;
               prd_next = {16'h0, rdv_reg, 7'h0, st_reg != hs_idle};
            end
            `BCF_A_PIX: begin
               prd_next = {31'h0, pend_reg};
               if (!pwrite) begin
                  rdy_next = 1'b1;
               end else if (!pend_reg) begin
                  rdy_next = 1'b1;
                  qd_next = pwdata[23:0];
                  qs_next = pwdata[24];
                  qp_next = pwdata[25];
                  pend_next = 1'b1;
               end
            end
            default: begin
               rdy_next = 1'b1;
               err_next = 1'b1;
               prd_next = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= 3'h0;
         prd_reg <= 32'h0;
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
         st_reg <= hs_idle;
         ca_reg <= 8'h00;
         cw_reg <= 8'h00;
         crd_reg <= 1'b0;
         rdv_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         pend_reg <= 1'b0;
         qs_reg <= 1'b0;
         qp_reg <= 1'b0;
         qd_reg <= 24'h000000;
         lclk_reg <= 1'b0;
         lv_reg <= 1'b0;
         ls_reg <= 1'b0;
         lp_reg <= 1'b0;
         ld_reg <= 24'h000000;
         div_reg <= 5'h00;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         prd_reg <= prd_next;
         rdy_reg <= rdy_next;
         err_reg <= err_next;
         st_reg <= st_next;
         ca_reg <= ca_next;
         cw_reg <= cw_next;
         crd_reg <= crd_next;
         rdv_reg <= rdv_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         pend_reg <= pend_next;
         qs_reg <= qs_next;
         qp_reg <= qp_next;
         qd_reg <= qd_next;
         lclk_reg <= lclk_next;
         lv_reg <= lv_next;
         ls_reg <= ls_next;
         lp_reg <= lp_next;
         ld_reg <= ld_next;
         div_reg <= div_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prd_reg;
   assign pready = rdy_reg;
   assign pslverr = err_reg;
   assign lnk.link_clk = lclk_reg;
   assign lnk.pix_valid = lv_reg;
   assign lnk.pix_sol = ls_reg;
   assign lnk.pix_port = lp_reg;
   assign lnk.pix_data = ld_reg;
   assign lnk.reg_wr = wr_reg;
   assign lnk.reg_rd = rd_reg;
   assign lnk.reg_addr = ca_reg;
   assign lnk.reg_wdata = cw_reg;
   assign lnk.dual_input_en = ctrl_reg[0];
   assign lnk.indep_mode = ctrl_reg[1];
   assign lnk.port_sel = ctrl_reg[2];
endmodule : bcf_host

// >>> test/bcf_checker.sv
`timescale 1ns/1ps
`include "bcf_map.svh"
module bcf_checker import bcf_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic pix_valid,
   input wire logic pix_sol,
   input wire bcf_pix_t pix_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic indep_mode,
   input wire logic port_sel
);
   logic [1:0] hi_reg, hi_next, m0_reg, m0_next, m1_reg, m1_next;
   logic lc_reg, seen_reg, seen_next, toggle;
   logic [4:0] cnt_reg, cnt_next;
   logic [7:0] exp_cfg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // -----------------------------
   // shadow of config and link clock spacing
   // -----------------------------
   always_comb begin
      hi_next = hi_reg;
      m0_next = m0_reg;
      m1_next = m1_reg;
      if (reg_wr && reg_addr == `BCF_CFG_ADDR) begin
         hi_next = reg_wdata[7:6];
         if (indep_mode && port_sel) begin
            m1_next = reg_wdata[1:0];
         end else if (indep_mode) begin
            m0_next = reg_wdata[1:0];
         end else if (reg_wdata[1:0] != 2'h3) begin
            m0_next = reg_wdata[1:0];
            m1_next = reg_wdata[1:0];
         end
      end
      toggle = link_clk != lc_reg;
      cnt_next = toggle ? 5'h00 : cnt_reg + 5'h01;
      seen_next = seen_reg | toggle;
   end
   // register the shadow state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hi_reg <= 2'h0;
         m0_reg <= 2'h0;
         m1_reg <= 2'h0;
         lc_reg <= 1'b0;
         cnt_reg <= 5'h00;
         seen_reg <= 1'b0;
      end else begin
         hi_reg <= hi_next;
         m0_reg <= m0_next;
         m1_reg <= m1_next;
         lc_reg <= link_clk;
         cnt_reg <= cnt_next;
         seen_reg <= seen_next;
      end
   end
   // readback seen by the selected port
   assign exp_cfg = {hi_reg, 4'h0, (indep_mode && port_sel) ? m1_reg : m0_reg};
   // -----------------------------
   // properties
   // -----------------------------
   a_ack_after_req: assert property (reg_wr || reg_rd |=> reg_ack)
      else $error("register ack missing");
   a_ack_needs_req: assert property (reg_ack |-> $past(reg_wr) || $past(reg_rd))
      else $error("register ack without request");
   a_cfg_readback: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == `BCF_CFG_ADDR
      |-> reg_rdata == $past(exp_cfg)) else $error("config readback wrong");
   a_reserved_zero: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == `BCF_CFG_ADDR
      |-> reg_rdata[5:2] == 4'h0) else $error("reserved bits not zero");
   a_unmapped_zero: assert property (reg_ack && $past(reg_rd)
      && !($past(reg_addr) inside {`BCF_CFG_ADDR, `BCF_LLEN_ADDR, `BCF_DLY_ADDR}) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_held: assert property (!reg_ack |-> $stable(reg_rdata))
      else $error("read data moved without ack");
   a_link_half: assert property (toggle && seen_reg |-> cnt_reg == `BCF_LINK_HALF)
      else $error("link clock half period wrong");
   a_pix_stable: assert property ($rose(link_clk) |-> $stable(pix_data) && $stable(pix_valid) && $stable(pix_sol))
      else $error("pixel changed at link rise");
endmodule : bcf_checker

// >>> test/test_bridge_clock_and_3d_format_cfg.sv
`timescale 1ns/1ps
`include "bcf_map.svh"
module test_bridge_clock_and_3d_format_cfg;
   typedef struct {logic [2:0] ctrl; logic [7:0] addr; logic wr; logic [7:0] wd; logic [7:0] ex;} bcf_row_s;
   typedef struct {logic [2:0] ctrl; logic [7:0] wd; int e0; int e1;} bcf_tick_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q_w;
   logic pready, pslverr, e_w, out_valid, out_sol, tx0_tick, tx1_tick;
   logic [6:0] tcnt = 7'h00;
   logic [7:0] dv;
   bcf_pkg::bcf_pix_t out_data;
   logic [24:0] got_q [$];
   logic [24:0] exp_q [$];
   int n_mismatch = 0;
   int num_checks = 0;
   int c0, c1;
   bcf_row_s rows [9] = '{'{3'h0, 8'h56, 1'b1, 8'hC1, 8'hC1}, '{3'h0, 8'h56, 1'b1, 8'h3E, 8'h02},
      '{3'h0, 8'h56, 1'b1, 8'h03, 8'h02}, '{3'h2, 8'h56, 1'b1, 8'h03, 8'h03}, '{3'h6, 8'h56, 1'b1, 8'h01, 8'h01},
      '{3'h2, 8'h56, 1'b0, 8'h00, 8'h03}, '{3'h0, 8'hE0, 1'b1, 8'h05, 8'h05}, '{3'h0, 8'h33, 1'b1, 8'hAA, 8'h00},
      '{3'h0, 8'hE1, 1'b1, 8'h5A, 8'h5A}};
   bcf_tick_s ticks [5] = '{'{3'h0, 8'h00, 20, 20}, '{3'h0, 8'h01, 10, 10}, '{3'h0, 8'h02, 64, 64},
      '{3'h2, 8'h03, 40, 64}, '{3'h6, 8'h03, 40, 5}};
   // -----------------------------
   // structure
   // -----------------------------
   bcf_if i_bcf_if();
   bcf_dev i_bcf_dev(.clk(clk), .nrst(nrst), .ce(ce), .lnk(i_bcf_if), .external_pixel_clock_in(tcnt[5]),
      .port0_pixel_clock_in(tcnt[3]), .port1_pixel_clock_in(tcnt[6]), .out_valid(out_valid), .out_sol(out_sol),
      .out_data(out_data), .tx0_tick(tx0_tick), .tx1_tick(tx1_tick));
   bcf_host i_bcf_host(.clk(clk), .nrst(nrst), .ce(ce), .lnk(i_bcf_if), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   bcf_checker i_bcf_checker(.clk(clk), .nrst(nrst), .link_clk(i_bcf_if.link_clk),
      .pix_valid(i_bcf_if.pix_valid), .pix_sol(i_bcf_if.pix_sol), .pix_data(i_bcf_if.pix_data),
      .reg_wr(i_bcf_if.reg_wr), .reg_rd(i_bcf_if.reg_rd), .reg_addr(i_bcf_if.reg_addr),
      .reg_wdata(i_bcf_if.reg_wdata), .reg_rdata(i_bcf_if.reg_rdata), .reg_ack(i_bcf_if.reg_ack),
      .indep_mode(i_bcf_if.indep_mode), .port_sel(i_bcf_if.port_sel));
   // clock, reference pins and output monitor
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      tcnt <= tcnt + 7'h01;
      if (out_valid === 1'b1) got_q.push_back({out_sol, out_data});
   end
   // -----------------------------
   // tasks
   // -----------------------------
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg
   task automatic chk_pix(input string nm, input logic [24:0] e, input logic [24:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_pix
   task automatic chk_cnt(input string nm, input int e, input int g);
      num_checks++;
      if (g != e) begin
         n_mismatch++;
         $display("unexpected %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q_w = prdata;
      e_w = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // device register access through the command register
   task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, `BCF_A_CMD, {15'h0, ~wr, a, d});
      apb(1'b0, `BCF_A_STAT, 32'h0);
      while (q_w[0] !== 1'b0) apb(1'b0, `BCF_A_STAT, 32'h0);
      dv = q_w[15:8];
   endtask : dev
   task automatic pix(input logic port, input logic sol, input logic [23:0] d);
      apb(1'b1, `BCF_A_PIX, {6'h0, port, sol, d});
   endtask : pix
   task automatic chk_line();
      repeat (200) @(posedge clk);
      chk_cnt("pixel count", exp_q.size(), got_q.size());
      foreach (exp_q[i]) begin
         if (i < got_q.size()) chk_pix("pixel", exp_q[i], got_q[i]);
      end
   endtask : chk_line
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   // -----------------------------
   // sequence
   // -----------------------------
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(1'b1, `BCF_A_CTRL, {29'h0, rows[i].ctrl});
         if (rows[i].wr) dev(1'b1, rows[i].addr, rows[i].wd);
         dev(1'b0, rows[i].addr, 8'h00);
         chk_reg("device readback", {24'h0, rows[i].ex}, {24'h0, dv});
      end
      foreach (ticks[i]) begin
         apb(1'b1, `BCF_A_CTRL, {29'h0, ticks[i].ctrl});
         dev(1'b1, `BCF_CFG_ADDR, ticks[i].wd);
         repeat (30) @(posedge clk);
         c0 = 0;
         c1 = 0;
         repeat (640) begin
            @(posedge clk);
            if (tx0_tick === 1'b1) c0++;
            if (tx1_tick === 1'b1) c1++;
         end
         chk_cnt("port0 ticks", ticks[i].e0, c0);
         chk_cnt("port1 ticks", ticks[i].e1, c1);
      end
      // passthrough, port1 dropped
      apb(1'b1, `BCF_A_CTRL, 32'h0);
      dev(1'b1, `BCF_CFG_ADDR, 8'h00);
      got_q.delete();
      pix(1'b0, 1'b1, 24'h123456);
      pix(1'b0, 1'b0, 24'hABCDEF);
      pix(1'b1, 1'b1, 24'h777777);
      exp_q = '{{1'b1, 24'h123456}, {1'b0, 24'hABCDEF}};
      chk_line();
      // side-by-side to alternating pixels
      dev(1'b1, `BCF_LLEN_ADDR, 8'h02);
      dev(1'b1, `BCF_CFG_ADDR, 8'h80);
      got_q.delete();
      pix(1'b0, 1'b1, 24'h0000A0);
      pix(1'b0, 1'b0, 24'h0000A1);
      pix(1'b0, 1'b0, 24'h0000B0);
      pix(1'b0, 1'b0, 24'h0000B1);
      exp_q = '{{1'b1, 24'h0000A0}, {1'b0, 24'h0000B0}, {1'b0, 24'h0000A1}, {1'b0, 24'h0000B1}};
      chk_line();
      // two ports merged into one line
      apb(1'b1, `BCF_A_CTRL, 32'h1);
      dev(1'b1, `BCF_CFG_ADDR, 8'h40);
      got_q.delete();
      pix(1'b0, 1'b1, 24'h0000C0);
      pix(1'b0, 1'b0, 24'h0000C1);
      pix(1'b1, 1'b1, 24'h0000D0);
      pix(1'b1, 1'b0, 24'h0000D1);
      exp_q = '{{1'b1, 24'h0000C0}, {1'b0, 24'h0000C1}, {1'b0, 24'h0000D0}, {1'b0, 24'h0000D1}};
      chk_line();
      // reset in mid-run, then refused apb access
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      dev(1'b0, `BCF_CFG_ADDR, 8'h00);
      chk_reg("config after reset", 32'h0, {24'h0, dv});
      apb(1'b0, `BCF_A_CTRL, 32'h0);
      chk_reg("ctrl after reset", 32'h0, q_w);
      apb(1'b0, 8'h20, 32'h0);
      chk_reg("apb error", 32'h1, {31'h0, e_w});
      chk_reg("apb rdata", 32'h0, q_w);
      complete_run();
   end
   // watchdog for a hung handshake
   initial begin
      #300000;
      n_mismatch++;
      $display("unexpected watchdog expected done seen timeout");
      complete_run();
   end
endmodule : test_bridge_clock_and_3d_format_cfg
